// *** verilog/sdm_lock_top.v ***
// Modulator configuration, charge pump float and digital lock detect with Avalon-MM registers
// Notes on behaviour
// R1: Order 0 integer, 1-4 fractional, 5-7 illegal
// R2: First order: no compensation, no dithering
// R3: Dither codes weak, medium, strong, 3 off
// R4: Software never dithers in integer/first order
// R5: Software should disable dither at zero numerator
// R6: Float bit set puts pump in high-impedance
// R7: Lock after five consecutive in-window cycles
// R8: Lock drives test/lock pin high
// R9: Hold lock until offset exceeds same window
// R10: Lost reference forces unlocked indication
// R11: Window codes 0-5 give 3.5-13.5 ns
// R12: Software keeps minimum window within 13.5 ns
// R13: Software keeps period margin at least 3.5 ns
// R14: Software keeps comparison rate within limits
// R15: Out-of-window cycle resets consecutive count
`timescale 1ns/1ps
`default_nettype none
`include "sdm_map.vh"
module sdm_lock_top #(
	parameter REF_LOSS_CYC = `SDM_REF_LOSS_CYC
) (
	input  wire                   clk,
	input  wire                   rstn,
	input  wire [`SDM_ADDR_W-1:0] avs_address,
	input  wire                   avs_read,
	input  wire                   avs_write,
	input  wire [31:0]            avs_writedata,
	output reg  [31:0]            avs_readdata,
	output reg                    avs_waitrequest,
	input  wire                   pd_event,
	input  wire [15:0]            pd_offset_ps,
	output reg  [2:0]             modulator_order,
	output reg                    integer_mode,
	output reg                    analog_comp_en,
	output reg                    noise_randomize_en,
	output reg  [1:0]             noise_randomize_strength,
	output reg                    pump_float,
	output reg                    lock_detect,
	output reg                    test_lock_pin_out,
	output reg                    test_lock_pin_oe,
	output reg                    irq
);
	reg  [2:0]             cfg_order;
	reg  [1:0]             cfg_noise_randomize_strength;
	reg                    cfg_float;
	reg  [2:0]             lock_window_select;
	reg  [2:0]             cfg_pin;
	reg  [`SDM_IRQ_W-1:0]  irq_status;
	reg  [`SDM_IRQ_W-1:0]  irq_mask;
	reg  [`SDM_TMO_W-1:0]  ref_idle;
	reg                    ref_lost;
	reg                    ref_lost_q;
	wire                   in_window;
	wire                   locked;
	wire                   gained;
	wire                   lost;
	wire                   take;
	wire                   ack;
	wire                   noise_randomize_strength_allowed;
	wire [2:0]             wr_order;
	wire [2:0]             wr_win;
	wire [`SDM_IRQ_W-1:0]  events;
	wire [`SDM_IRQ_W-1:0]  rd_clear;
	reg  [31:0]            next_readdata;
	reg                    next_pin_out;
	reg                    next_pin_oe;

	sdm_window_cmp u_window (
		.win_sel   (lock_window_select),
		.offset_ps (pd_offset_ps),
		.in_window (in_window)
	);

	sdm_lock_count u_count (
		.clk          (clk),
		.rstn         (rstn),
		.pd_event     (pd_event),
		.in_window    (in_window),
		.force_unlock (ref_lost),
		.locked       (locked),
		.gained       (gained),
		.lost         (lost)
	);

	// One access is served per request; the wait state gives one cycle to decode
	assign take     = (avs_read | avs_write) & avs_waitrequest;
	// Writes land only at the edge where the master sees waitrequest low
	assign ack      = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_order = avs_writedata[`SDM_CTRL_ORDER_MSB:`SDM_CTRL_ORDER_LSB];
	assign wr_win   = avs_writedata[`SDM_CTRL_WIN_MSB:`SDM_CTRL_WIN_LSB];

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			if (take) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// Control register writes; illegal or reserved codes leave the field as it was
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_order          <= `SDM_RST_ORDER;
			cfg_noise_randomize_strength           <= `SDM_RST_NOISE_RANDOMIZE_STRENGTH;
			cfg_float          <= 1'b0;
			lock_window_select <= `SDM_RST_WIN;
			cfg_pin            <= `SDM_RST_PIN;
			irq_mask           <= {`SDM_IRQ_W{1'b0}};
		end else if (ack && avs_write) begin
			if (avs_address == `SDM_OFF_CTRL) begin
				if (wr_order <= `SDM_ORDER_MAX) begin
					cfg_order <= wr_order; // R1
				end
				cfg_noise_randomize_strength  <= avs_writedata[`SDM_CTRL_NOISE_RANDOMIZE_STRENGTH_MSB:`SDM_CTRL_NOISE_RANDOMIZE_STRENGTH_LSB]; // R3
				cfg_float <= avs_writedata[`SDM_CTRL_FLOAT_BIT]; // R6
				if (wr_win <= `SDM_WIN_MAX) begin
					lock_window_select <= wr_win; // R11
				end
				if (avs_writedata[`SDM_CTRL_PIN_MSB:`SDM_CTRL_PIN_LSB] <= `SDM_PIN_LOCK_OD) begin
					cfg_pin <= avs_writedata[`SDM_CTRL_PIN_MSB:`SDM_CTRL_PIN_LSB];
				end
			end else if (avs_address == `SDM_OFF_IRQ_MASK) begin
				irq_mask <= avs_writedata[`SDM_IRQ_W-1:0];
			end
		end
	end

	always @* begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			`SDM_OFF_CTRL: begin
				next_readdata[`SDM_CTRL_ORDER_MSB:`SDM_CTRL_ORDER_LSB] = cfg_order;
				next_readdata[`SDM_CTRL_NOISE_RANDOMIZE_STRENGTH_MSB:`SDM_CTRL_NOISE_RANDOMIZE_STRENGTH_LSB]   = cfg_noise_randomize_strength;
				next_readdata[`SDM_CTRL_FLOAT_BIT]                     = cfg_float;
				next_readdata[`SDM_CTRL_WIN_MSB:`SDM_CTRL_WIN_LSB]     = lock_window_select;
				next_readdata[`SDM_CTRL_PIN_MSB:`SDM_CTRL_PIN_LSB]     = cfg_pin;
			end
			`SDM_OFF_STATUS: begin
				next_readdata[`SDM_ST_LOCK_BIT]  = locked;
				next_readdata[`SDM_ST_NOISE_RANDOMIZE_STRENGTH_BIT]  = noise_randomize_en;
				next_readdata[`SDM_ST_COMP_BIT]  = analog_comp_en;
				next_readdata[`SDM_ST_INT_BIT]   = integer_mode;
				next_readdata[`SDM_ST_REFOK_BIT] = ~ref_lost;
			end
			`SDM_OFF_IRQ_STATUS: begin
				next_readdata[`SDM_IRQ_W-1:0] = irq_status;
			end
			`SDM_OFF_IRQ_MASK: begin
				next_readdata[`SDM_IRQ_W-1:0] = irq_mask;
			end
			default: begin
				next_readdata = 32'h0000_0000;
			end
		endcase
	end

	// Reference loss: no comparison event for a long stretch means the divider has stopped
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ref_idle   <= {`SDM_TMO_W{1'b0}};
			ref_lost   <= 1'b0;
			ref_lost_q <= 1'b0;
		end else begin
			ref_lost_q <= ref_lost;
			if (pd_event) begin
				ref_idle <= {`SDM_TMO_W{1'b0}};
				ref_lost <= 1'b0;
			end else if (ref_idle >= REF_LOSS_CYC[`SDM_TMO_W-1:0] - 1'b1) begin
				ref_lost <= 1'b1; // R10
			end else begin
				ref_idle <= ref_idle + 1'b1;
			end
		end
	end

	// Sticky events; a new event in the clearing read cycle survives
	assign events[`SDM_IRQ_GAIN_BIT] = gained;
	assign events[`SDM_IRQ_LOSS_BIT] = lost;
	assign events[`SDM_IRQ_REF_BIT]  = ref_lost & ~ref_lost_q;
	assign rd_clear = (take && avs_read && avs_address == `SDM_OFF_IRQ_STATUS) ?
		{`SDM_IRQ_W{1'b1}} : {`SDM_IRQ_W{1'b0}};

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_status <= {`SDM_IRQ_W{1'b0}};
			irq        <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~rd_clear) | events;
			irq        <= |(((irq_status & ~rd_clear) | events) & irq_mask);
		end
	end

	// Dithering is suppressed in integer and first order whatever software asks
	assign noise_randomize_strength_allowed = (cfg_order != `SDM_ORDER_INT) && (cfg_order != `SDM_ORDER_FIRST);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modulator_order          <= `SDM_RST_ORDER;
			integer_mode             <= 1'b0;
			analog_comp_en           <= 1'b0;
			noise_randomize_en       <= 1'b0;
			noise_randomize_strength <= `SDM_NOISE_RANDOMIZE_STRENGTH_WEAK;
			pump_float               <= 1'b0;
			lock_detect              <= 1'b0;
		end else begin
			modulator_order          <= cfg_order; // R1
			integer_mode             <= (cfg_order == `SDM_ORDER_INT); // R1
			analog_comp_en           <= noise_randomize_strength_allowed; // R2
			noise_randomize_en       <= noise_randomize_strength_allowed && (cfg_noise_randomize_strength != `SDM_NOISE_RANDOMIZE_STRENGTH_OFF); // R2
			noise_randomize_strength <= (cfg_noise_randomize_strength == `SDM_NOISE_RANDOMIZE_STRENGTH_OFF) ?
				`SDM_NOISE_RANDOMIZE_STRENGTH_WEAK : cfg_noise_randomize_strength; // R3
			pump_float               <= cfg_float; // R6
			lock_detect              <= locked;
		end
	end

	// Test/lock pin driver; open drain only ever pulls low
	always @* begin
		case (cfg_pin)
			`SDM_PIN_HIZ: begin
				next_pin_out = 1'b0;
				next_pin_oe  = 1'b0;
			end
			`SDM_PIN_HIGH: begin
				next_pin_out = 1'b1;
				next_pin_oe  = 1'b1;
			end
			`SDM_PIN_LOW: begin
				next_pin_out = 1'b0;
				next_pin_oe  = 1'b1;
			end
			`SDM_PIN_LOCK: begin
				next_pin_out = locked; // R8
				next_pin_oe  = 1'b1;
			end
			`SDM_PIN_LOCK_INV: begin
				next_pin_out = ~locked;
				next_pin_oe  = 1'b1;
			end
			`SDM_PIN_LOCK_OD: begin
				next_pin_out = 1'b0;
				next_pin_oe  = ~locked; // R8
			end
			default: begin
				next_pin_out = 1'b0;
				next_pin_oe  = 1'b0;
			end
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			test_lock_pin_out <= 1'b0;
			test_lock_pin_oe  <= 1'b1;
		end else begin
			test_lock_pin_out <= next_pin_out;
			test_lock_pin_oe  <= next_pin_oe;
		end
	end
endmodule
`default_nettype wire

// *** verilog/sdm_map.vh ***
// Register map, field positions, codes and timing constants of the modulator control block
`ifndef SDM_MAP_VH
`define SDM_MAP_VH

`define SDM_CLK_NS          100
`define SDM_REF_LOSS_NS     10000
`define SDM_REF_LOSS_CYC    (`SDM_REF_LOSS_NS / `SDM_CLK_NS)
`define SDM_LOCK_RUN        3'h5
`define SDM_TMO_W           16

`define SDM_ADDR_W          4
`define SDM_OFF_CTRL        4'h0
`define SDM_OFF_STATUS      4'h4
`define SDM_OFF_IRQ_STATUS  4'h8
`define SDM_OFF_IRQ_MASK    4'hC

`define SDM_CTRL_ORDER_LSB  0
`define SDM_CTRL_ORDER_MSB  2
`define SDM_CTRL_NOISE_RANDOMIZE_STRENGTH_LSB   4
`define SDM_CTRL_NOISE_RANDOMIZE_STRENGTH_MSB   5
`define SDM_CTRL_FLOAT_BIT  8
`define SDM_CTRL_WIN_LSB    12
`define SDM_CTRL_WIN_MSB    14
`define SDM_CTRL_PIN_LSB    16
`define SDM_CTRL_PIN_MSB    18

`define SDM_ORDER_INT       3'h0
`define SDM_ORDER_FIRST     3'h1
`define SDM_ORDER_MAX       3'h4
`define SDM_NOISE_RANDOMIZE_STRENGTH_WEAK       2'h0
`define SDM_NOISE_RANDOMIZE_STRENGTH_OFF        2'h3
`define SDM_WIN_MAX         3'h5

`define SDM_PIN_HIZ         3'h0
`define SDM_PIN_HIGH        3'h1
`define SDM_PIN_LOW         3'h2
`define SDM_PIN_LOCK        3'h3
`define SDM_PIN_LOCK_INV    3'h4
`define SDM_PIN_LOCK_OD     3'h5

`define SDM_RST_ORDER       3'h3
`define SDM_RST_NOISE_RANDOMIZE_STRENGTH        2'h3
`define SDM_RST_WIN         3'h0
`define SDM_RST_PIN         3'h3

`define SDM_WIN0_PS         16'h0DAC
`define SDM_WIN1_PS         16'h157C
`define SDM_WIN2_PS         16'h1D4C
`define SDM_WIN3_PS         16'h251C
`define SDM_WIN4_PS         16'h2CEC
`define SDM_WIN5_PS         16'h34BC

`define SDM_IRQ_GAIN_BIT    0
`define SDM_IRQ_LOSS_BIT    1
`define SDM_IRQ_REF_BIT     2
`define SDM_IRQ_W           3

`define SDM_ST_LOCK_BIT     0
`define SDM_ST_NOISE_RANDOMIZE_STRENGTH_BIT     1
`define SDM_ST_COMP_BIT     2
`define SDM_ST_INT_BIT      3
`define SDM_ST_REFOK_BIT    4

`endif

// *** verilog/sdm_window_cmp.v ***
// Window lookup and offset comparator for the lock detector
`timescale 1ns/1ps
`default_nettype none
`include "sdm_map.vh"
module sdm_window_cmp (
	input  wire [2:0]  win_sel,
	input  wire [15:0] offset_ps,
	output reg         in_window
);
	reg [15:0] limit_ps;
	always @* begin
		case (win_sel) // R11
			3'h0: limit_ps = `SDM_WIN0_PS;
			3'h1: limit_ps = `SDM_WIN1_PS;
			3'h2: limit_ps = `SDM_WIN2_PS;
			3'h3: limit_ps = `SDM_WIN3_PS;
			3'h4: limit_ps = `SDM_WIN4_PS;
			default: limit_ps = `SDM_WIN5_PS;
		endcase
		// Same window for lock and unlock
		in_window = (offset_ps < limit_ps); // R9
	end
endmodule
`default_nettype wire

// *** verilog/sdm_lock_count.v ***
// Consecutive in-window counter and lock state
`timescale 1ns/1ps
`default_nettype none
`include "sdm_map.vh"
module sdm_lock_count (
	input  wire clk,
	input  wire rstn,
	input  wire pd_event,
	input  wire in_window,
	input  wire force_unlock,
	output reg  locked,
	output reg  gained,
	output reg  lost
);
	reg [2:0] run;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run    <= 3'h0;
			locked <= 1'b0;
			gained <= 1'b0;
			lost   <= 1'b0;
		end else begin
			gained <= 1'b0;
			lost   <= 1'b0;
			// The event that ends a silence counts, so a returning reference is not lost
			if (pd_event) begin
				if (!in_window) begin
					run    <= 3'h0; // R15
					locked <= 1'b0; // R9
					lost   <= locked;
				end else if (!locked) begin
					if (run == `SDM_LOCK_RUN - 3'h1) begin
						run    <= 3'h0;
						locked <= 1'b1; // R7
						gained <= 1'b1;
					end else begin
						run <= run + 3'h1; // R7
					end
				end
			end else if (force_unlock) begin
				run    <= 3'h0; // R10
				locked <= 1'b0;
				lost   <= locked;
			end
		end
	end
endmodule
`default_nettype wire

// *** testbench/sdm_lock_asserts.sv ***
// Port checks for the lock detect block
`timescale 1ns/1ps
`default_nettype none
module sdm_lock_asserts #(
	parameter REF_LOSS_CYC = 8
) (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       pd_event,
	input wire logic [15:0] pd_offset_ps,
	input wire logic [2:0] modulator_order,
	input wire logic       integer_mode,
	input wire logic       analog_comp_en,
	input wire logic       noise_randomize_en,
	input wire logic [1:0] noise_randomize_strength,
	input wire logic       lock_detect
);
	logic [7:0] idle;
	// Saturates so a long silence cannot wrap back to a small count
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			idle <= 8'h00;
		else if (pd_event)
			idle <= 8'h00;
		else if (idle != 8'hFF)
			idle <= idle + 8'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Beyond the widest window, so out of window whatever code is set
	sequence far_event;
		pd_event && pd_offset_ps >= 16'h34BC;
	endsequence
	sequence stays_unlocked;
		!lock_detect [*5];
	endsequence
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	a_order_legal: assert property (modulator_order <= 3'h4)
		else $error("illegal modulator order");
	a_integer_flag: assert property (integer_mode == (modulator_order == 3'h0))
		else $error("integer flag disagrees with order");
	a_first_plain: assert property (modulator_order <= 3'h1 |-> !analog_comp_en && !noise_randomize_en)
		else $error("compensation or dither in order 0 or 1");
	a_dither_code: assert property (noise_randomize_en |-> noise_randomize_strength != 2'h3)
		else $error("dither enabled with off code");
	a_far_unlock: assert property (far_event |=> ##1 stays_unlocked)
		else $error("lock held or regained too soon after out-of-window event");
	a_lock_cause: assert property ($rose(lock_detect) |-> $past(pd_event, 2))
		else $error("lock rose without a comparison event");
	a_ref_loss: assert property (idle > REF_LOSS_CYC + 2 |-> !lock_detect)
		else $error("lock kept without reference");
endmodule
bind sdm_lock_top sdm_lock_asserts #(.REF_LOSS_CYC(REF_LOSS_CYC)) u_chk (
	.clk(clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .pd_event(pd_event), .pd_offset_ps(pd_offset_ps),
	.modulator_order(modulator_order), .integer_mode(integer_mode),
	.analog_comp_en(analog_comp_en), .noise_randomize_en(noise_randomize_en),
	.noise_randomize_strength(noise_randomize_strength), .lock_detect(lock_detect)
);
`default_nettype wire

// *** testbench/sdm_pd_source.sv ***
// Comparison event source standing for the divider edge measurement
`timescale 1ns/1ps
`default_nettype none
module sdm_pd_source (
	input  wire logic        run,
	input  wire logic [15:0] offset,
	output wire logic        pd_event,
	output wire logic [15:0] pd_offset_ps
);
	// At most one comparison per cycle keeps the rate legal
	assign pd_event     = run;
	// Idle offset is garbage, never the last valid value
	assign pd_offset_ps = run ? offset : ~offset;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the modulator control and lock detect block
`timescale 1ns/1ps
`default_nettype none
`include "sdm_map.vh"
module tb_top;
	localparam int LOSS = 8;
	// Unlocked pin drive {oe, out} for modes 0 to 5, two bits per mode
	localparam logic [11:0] PIN_EXP = 12'hBAC;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        run = 1'b0;
	logic [15:0] offset = 16'h0000;
	logic        pd_event;
	logic [15:0] pd_offset_ps;
	logic [2:0]  modulator_order;
	logic [1:0]  noise_randomize_strength;
	logic        integer_mode, analog_comp_en, noise_randomize_en, pump_float;
	logic        lock_detect, pin_out, pin_oe, irq;
	logic [31:0] rdata, prev;
	logic [15:0] win;
	int          err_total = 0;
	int          n_checks = 0;
	always #50 clk = ~clk;
	sdm_pd_source i_src (.run(run), .offset(offset), .pd_event(pd_event),
		.pd_offset_ps(pd_offset_ps));
	sdm_lock_top #(.REF_LOSS_CYC(LOSS)) i_dut (.clk(clk), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pd_event(pd_event), .pd_offset_ps(pd_offset_ps),
		.modulator_order(modulator_order), .integer_mode(integer_mode),
		.analog_comp_en(analog_comp_en), .noise_randomize_en(noise_randomize_en),
		.noise_randomize_strength(noise_randomize_strength), .pump_float(pump_float),
		.lock_detect(lock_detect), .test_lock_pin_out(pin_out), .test_lock_pin_oe(pin_oe),
		.irq(irq));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 40)
			err_total++;
		// Registered outputs follow one edge after the write lands
		@(posedge clk);
		#1;
	endtask
	// Events on consecutive cycles, then one edge for lock outputs to follow
	task automatic ev(input int cnt, input logic [15:0] off);
		@(posedge clk);
		run <= 1'b1;
		offset <= off;
		repeat (cnt) @(posedge clk);
		run <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, `SDM_OFF_CTRL, 32'h0000_0000);
		chk(rdata, 32'h0003_0033);
		prev = 32'h0000_0003;
		for (int o = 0; o < 8; o++) begin
			bus(1'b1, `SDM_OFF_CTRL, 32'h0003_0030 | o);
			if (o < 5)
				prev = o;
			chk(modulator_order, prev);
			chk(integer_mode, prev == 0);
			chk(analog_comp_en, prev > 1);
		end
		for (int d = 0; d < 4; d++) begin
			bus(1'b1, `SDM_OFF_CTRL, 32'h0003_0003 | (d << 4));
			chk(noise_randomize_en, d != 3);
			chk(noise_randomize_strength, (d == 3) ? 0 : d);
		end
		bus(1'b1, `SDM_OFF_CTRL, 32'h0003_0001);
		chk(noise_randomize_en, 0);
		bus(1'b1, `SDM_OFF_CTRL, 32'h0003_0133);
		chk(pump_float, 1);
		bus(1'b1, `SDM_OFF_CTRL, 32'h0003_0033);
		chk(pump_float, 0);
		// Code 6 is reserved, so the last loop pass keeps the widest window
		for (int w = 0; w < 7; w++) begin
			bus(1'b1, `SDM_OFF_CTRL, 32'h0003_0033 | (w << 12));
			win = (w < 6) ? 16'h0DAC + 16'h07D0 * w[15:0] : 16'h34BC;
			ev(4, win - 16'h0001);
			chk(lock_detect, 0);
			ev(1, win - 16'h0001);
			chk(lock_detect, 1);
			chk({pin_oe, pin_out}, 2'b11);
			ev(1, win);
			chk(lock_detect, 0);
		end
		ev(4, 16'h0000);
		ev(1, 16'hFFFF);
		ev(4, 16'h0000);
		chk(lock_detect, 0);
		ev(1, 16'h0000);
		chk(lock_detect, 1);
		repeat (LOSS + 4) @(posedge clk);
		#1;
		chk(lock_detect, 0);
		bus(1'b0, `SDM_OFF_STATUS, 32'h0000_0000);
		chk(rdata, 32'h0000_0004);
		for (int p = 0; p < 6; p++) begin
			bus(1'b1, `SDM_OFF_CTRL, 32'h0000_0033 | (p << 16));
			chk({pin_oe, pin_out}, PIN_EXP[2*p +: 2]);
		end
		bus(1'b1, `SDM_OFF_CTRL, 32'h0003_0033);
		bus(1'b1, `SDM_OFF_IRQ_MASK, 32'h0000_0007);
		ev(1, 16'h0000);
		bus(1'b0, `SDM_OFF_IRQ_STATUS, 32'h0000_0000);
		ev(5, 16'h0000);
		chk(irq, 1);
		bus(1'b0, `SDM_OFF_IRQ_STATUS, 32'h0000_0000);
		chk(rdata, 32'h0000_0001);
		chk(irq, 0);
		bus(1'b1, `SDM_OFF_IRQ_MASK, 32'h0000_0000);
		ev(1, 16'hFFFF);
		chk(irq, 0);
		bus(1'b0, 4'h1, 32'h0000_0000);
		chk(rdata, 32'h0000_0000);
		complete_run();
	end
endmodule
`default_nettype wire
